// file: pcrlc_defs.vh
`ifndef PCRLC_DEFS_VH
`define PCRLC_DEFS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCRLC_CLK_PERIOD_NS 25
`define PCRLC_RC2M_DIV 20
`define PCRLC_SLOW_DIV 64
`define PCRLC_STRETCH_PERIODS 256
`define PCRLC_SETTLE_NS 10000
`define PCRLC_SETTLE_CYC \
  ((`PCRLC_SETTLE_NS + `PCRLC_CLK_PERIOD_NS - 1) / `PCRLC_CLK_PERIOD_NS)
`define PCRLC_RECAL_RST 16'h0100

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PCRLC_ADR_CTRL 8'h00
`define PCRLC_ADR_STATUS 8'h04
`define PCRLC_ADR_MASK 8'h08
`define PCRLC_ADR_STATE 8'h0c
`define PCRLC_ADR_RECAL 8'h10

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define PCRLC_CTRL_CPU_LSB 0
`define PCRLC_CTRL_LPDIV 2
`define PCRLC_CTRL_ACCURATE 3
`define PCRLC_CTRL_PSTATE_LSB 4
`define PCRLC_CTRL_CAP_LSB 6
`define PCRLC_CTRL_BOOST 9
`define PCRLC_CTRL_WIDTH 10
`define PCRLC_CTRL_RST 10'h000

// ----------------------------------------
// Event bits
// ----------------------------------------
`define PCRLC_EV_SUPPLY_LOW 0
`define PCRLC_EV_BANDGAP 1
`define PCRLC_EV_RST_DONE 2
`define PCRLC_EV_SEQ_ERR 3
`define PCRLC_EV_RECAL 4
`define PCRLC_EV_SETTLED 5
`define PCRLC_EV_WIDTH 6
`define PCRLC_MASK_RST 6'h00

// ----------------------------------------
// Encodings
// ----------------------------------------
`define PCRLC_CPU_RC26 2'h0
`define PCRLC_CPU_XO26 2'h1
`define PCRLC_CPU_RC2M 2'h2
`define PCRLC_PS_DOWN 2'h0
`define PCRLC_PS_CPU 2'h1
`define PCRLC_PS_LOWPWR 2'h2
`define PCRLC_PS_RADIO 2'h3

// Load capacitance in quarter pF
`define PCRLC_CAP_BASE_Q 6'h04
`define PCRLC_CAP_STEP_Q 6'h05
`define PCRLC_CAP_BOOST_Q 6'h14

`endif

// file: pcrlc_stretch.v
`timescale 1ns/10ps
`include "pcrlc_defs.vh"

module pcrlc_stretch #(
  parameter PERIODS = `PCRLC_STRETCH_PERIODS,
  parameter DIV = `PCRLC_SLOW_DIV,
  parameter CW = 14
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control
  input wire tick_2m,
  input wire hold,
  // Status
  output wire rst_active,
  output wire done_pulse
);

  localparam integer LAST_I = PERIODS * DIV - 1;
  localparam [CW-1:0] LAST = LAST_I[CW-1:0];

  reg [CW-1:0] cnt_ff;
  reg busy_ff;
  reg done_ff;

  // ----------------------------------------
  // Stretch counter
  // ----------------------------------------
  // Whole count in 2MHz ticks so a restart always gives a full period
  always @(posedge clk) begin
    if (srst) begin
      cnt_ff <= {CW{1'b0}};
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (hold) begin
        cnt_ff <= {CW{1'b0}};
        busy_ff <= 1'b1;
      end else if (busy_ff && tick_2m) begin
        if (cnt_ff == LAST) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign rst_active = busy_ff;
  assign done_pulse = done_ff;

endmodule // pcrlc_stretch

// file: pcrlc_top.v
// Notes on behaviour
// - Stretch reset 256 periods of 2MHz/64
// - Supply-low flag high while rail low
// - Bandgap-drop flag high while reference low
// - Slow clock is 2MHz divided by 64
// - Slow clock stable 10us after request
// - Processor clock nominal 26MHz for core, peripherals
// - Crystal clock whenever radio or accuracy needed
// - 2MHz RC selectable as processor clock
// - Low-power clock feeds always-on domain
// - Low-power source: 2MHz or divided slow
// - Slow RC clock recalibrated during radio timing
// - Load cap 1.00pF plus 1.25pF per code
// - Boost bit adds 5pF load cap
// - Fused crystal trim applied after reset
// - Request low powers down; request high once reset is released enters processor-only
`timescale 1ns/10ps
`include "pcrlc_defs.vh"

module pcrlc_top #(
  parameter RC2M_DIV = `PCRLC_RC2M_DIV,
  parameter SLOW_DIV = `PCRLC_SLOW_DIV,
  parameter SETTLE_CYC = `PCRLC_SETTLE_CYC,
  parameter TRIM_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire irq,
  // Pins and detectors
  input wire supply_low_det,
  input wire bandgap_drop_detect,
  input wire pwr_up_req,
  input wire io_supply,
  // Same-clock inputs
  input wire radio_busy,
  input wire [TRIM_W-1:0] fuse_xo_trim,
  // Reset and clock control
  output wire chip_rst,
  output wire slow_clock_settled,
  output wire lp_clk_en,
  output wire [1:0] cpu_clk_sel,
  output wire [1:0] pwr_state,
  output wire [2:0] load_cap_code,
  output wire load_cap_boost,
  output wire [TRIM_W-1:0] xo_trim
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] sel;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          wmerge[i*8 +: 8] = din[i*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [3:0] pin_raw;
  wire [3:0] pin_s;
  assign pin_raw = {io_supply, pwr_up_req, bandgap_drop_detect,
                    supply_low_det};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      reg meta_ff;
      reg sync_ff;
      always @(posedge clk) begin
        if (srst) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= pin_raw[g];
          sync_ff <= meta_ff;
        end
      end
      assign pin_s[g] = sync_ff;
    end
  endgenerate

  wire supply_low_s;
  wire bandgap_s;
  wire req_s;
  wire io_s;
  assign supply_low_s = pin_s[0];
  assign bandgap_s = pin_s[1];
  assign req_s = pin_s[2];
  assign io_s = pin_s[3];

  reg supply_low_d_ff;
  reg bandgap_d_ff;
  reg req_d_ff;
  reg io_d_ff;
  always @(posedge clk) begin
    if (srst) begin
      supply_low_d_ff <= 1'b0;
      bandgap_d_ff <= 1'b0;
      req_d_ff <= 1'b0;
      io_d_ff <= 1'b0;
    end else begin
      supply_low_d_ff <= supply_low_s;
      bandgap_d_ff <= bandgap_s;
      req_d_ff <= req_s;
      io_d_ff <= io_s;
    end
  end

  wire req_rise;
  wire req_fall;
  wire io_fall;
  assign req_rise = req_s & ~req_d_ff;
  assign req_fall = ~req_s & req_d_ff;
  assign io_fall = ~io_s & io_d_ff;

  // ----------------------------------------
  // 2MHz and slow tick dividers
  // ----------------------------------------
  reg [4:0] div2m_ff;
  reg tick2m_ff;
  reg [5:0] div_slow_ff;
  reg tick_slow_ff;
  always @(posedge clk) begin
    if (srst) begin
      div2m_ff <= 5'h00;
      tick2m_ff <= 1'b0;
      div_slow_ff <= 6'h00;
      tick_slow_ff <= 1'b0;
    end else begin
      tick2m_ff <= 1'b0;
      tick_slow_ff <= 1'b0;
      if (div2m_ff == RC2M_DIV[4:0] - 5'h01) begin
        div2m_ff <= 5'h00;
        tick2m_ff <= 1'b1;
      end else begin
        div2m_ff <= div2m_ff + 5'h01;
      end
      if (tick2m_ff) begin
        if (div_slow_ff == SLOW_DIV[5:0] - 6'h01) begin
          div_slow_ff <= 6'h00;
          tick_slow_ff <= 1'b1;
        end else begin
          div_slow_ff <= div_slow_ff + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Reset stretch
  // ----------------------------------------
  wire stretch_busy;
  wire stretch_done;
  pcrlc_stretch #(
    .PERIODS(`PCRLC_STRETCH_PERIODS),
    .DIV(SLOW_DIV),
    .CW(14)
  ) u_stretch (
    .clk(clk),
    .srst(srst),
    .tick_2m(tick2m_ff),
    .hold(supply_low_s | bandgap_s),
    .rst_active(stretch_busy),
    .done_pulse(stretch_done)
  );

  reg chip_rst_ff;
  always @(posedge clk) begin
    if (srst) begin
      chip_rst_ff <= 1'b1;
    end else begin
      chip_rst_ff <= stretch_busy | supply_low_s | bandgap_s;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [`PCRLC_CTRL_WIDTH-1:0] ctrl_ff;
  reg [`PCRLC_EV_WIDTH-1:0] status_ff;
  reg [`PCRLC_EV_WIDTH-1:0] mask_ff;
  reg [15:0] recal_per_ff;
  reg [31:0] rdata_ff;
  reg ack_ff;
  reg irq_ff;

  wire bus_req;
  wire bus_wr;
  wire bus_rd;
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_rd = bus_req & ~wb_we_i;

  wire [1:0] cpu_req;
  wire lp_div_sel;
  wire accurate_req;
  wire [1:0] pstate_req;
  assign cpu_req = ctrl_ff[`PCRLC_CTRL_CPU_LSB +: 2];
  assign lp_div_sel = ctrl_ff[`PCRLC_CTRL_LPDIV];
  assign accurate_req = ctrl_ff[`PCRLC_CTRL_ACCURATE];
  assign pstate_req = ctrl_ff[`PCRLC_CTRL_PSTATE_LSB +: 2];

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  reg [1:0] pstate_ff;
  reg [1:0] nxt_pstate;
  always @* begin
    nxt_pstate = pstate_ff;
    case (pstate_ff)
      `PCRLC_PS_DOWN: begin
        // Level, so a request raised during the reset pulse is kept
        if (req_s && !chip_rst_ff) begin
          nxt_pstate = `PCRLC_PS_CPU;
        end
      end
      `PCRLC_PS_CPU, `PCRLC_PS_LOWPWR, `PCRLC_PS_RADIO: begin
        if (pstate_req != `PCRLC_PS_DOWN) begin
          nxt_pstate = pstate_req;
        end
      end
      default: begin
        nxt_pstate = `PCRLC_PS_DOWN;
      end
    endcase
    if (!req_s || chip_rst_ff) begin
      nxt_pstate = `PCRLC_PS_DOWN;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      pstate_ff <= `PCRLC_PS_DOWN;
    end else begin
      pstate_ff <= nxt_pstate;
    end
  end

  // ----------------------------------------
  // Slow clock settle timer
  // ----------------------------------------
  reg [15:0] settle_cnt_ff;
  reg settled_ff;
  reg settle_ev;
  always @(posedge clk) begin
    if (srst) begin
      settle_cnt_ff <= 16'h0000;
      settled_ff <= 1'b0;
      settle_ev <= 1'b0;
    end else begin
      settle_ev <= 1'b0;
      if (!req_s || req_rise) begin
        settle_cnt_ff <= 16'h0000;
        settled_ff <= 1'b0;
      end else if (!settled_ff) begin
        if (settle_cnt_ff == SETTLE_CYC[15:0] - 16'h0001) begin
          settled_ff <= 1'b1;
          settle_ev <= 1'b1;
        end else begin
          settle_cnt_ff <= settle_cnt_ff + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Clock selection
  // ----------------------------------------
  // Radio activity forces the crystal regardless of software choice
  wire radio_on;
  assign radio_on = radio_busy | (pstate_ff == `PCRLC_PS_RADIO);

  reg [1:0] cpu_sel_ff;
  reg [1:0] nxt_cpu_sel;
  always @* begin
    nxt_cpu_sel = `PCRLC_CPU_RC26;
    if (radio_on || accurate_req) begin
      nxt_cpu_sel = `PCRLC_CPU_XO26;
    end else if (cpu_req == `PCRLC_CPU_RC2M) begin
      nxt_cpu_sel = `PCRLC_CPU_RC2M;
    end else if (cpu_req == `PCRLC_CPU_XO26) begin
      nxt_cpu_sel = `PCRLC_CPU_XO26;
    end
  end

  reg lp_en_ff;
  always @(posedge clk) begin
    if (srst) begin
      cpu_sel_ff <= `PCRLC_CPU_RC26;
      lp_en_ff <= 1'b0;
    end else begin
      cpu_sel_ff <= nxt_cpu_sel;
      // Always-on domain enable, only once the slow clock is trusted
      lp_en_ff <= (lp_div_sel ? tick_slow_ff : tick2m_ff) &
                  settled_ff;
    end
  end

  // ----------------------------------------
  // Recalibration reminder
  // ----------------------------------------
  reg [15:0] recal_cnt_ff;
  reg recal_ev;
  always @(posedge clk) begin
    if (srst) begin
      recal_cnt_ff <= 16'h0000;
      recal_ev <= 1'b0;
    end else begin
      recal_ev <= 1'b0;
      if (!(lp_div_sel && radio_on)) begin
        recal_cnt_ff <= 16'h0000;
      end else if (tick_slow_ff) begin
        if (recal_cnt_ff >= recal_per_ff - 16'h0001) begin
          recal_cnt_ff <= 16'h0000;
          recal_ev <= 1'b1;
        end else begin
          recal_cnt_ff <= recal_cnt_ff + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Crystal trim and load capacitance
  // ----------------------------------------
  reg [TRIM_W-1:0] trim_ff;
  reg trim_loaded_ff;
  reg [5:0] cap_q_ff;
  always @(posedge clk) begin
    if (srst) begin
      trim_ff <= {TRIM_W{1'b0}};
      trim_loaded_ff <= 1'b0;
      cap_q_ff <= `PCRLC_CAP_BASE_Q;
    end else begin
      // Fuses are sampled once, after reset release
      if (!trim_loaded_ff) begin
        trim_ff <= fuse_xo_trim;
        trim_loaded_ff <= 1'b1;
      end
      cap_q_ff <= `PCRLC_CAP_BASE_Q +
        ({3'h0, ctrl_ff[`PCRLC_CTRL_CAP_LSB +: 3]} *
         `PCRLC_CAP_STEP_Q) +
        (ctrl_ff[`PCRLC_CTRL_BOOST] ? `PCRLC_CAP_BOOST_Q : 6'h00);
    end
  end

  // ----------------------------------------
  // Events
  // ----------------------------------------
  wire [`PCRLC_EV_WIDTH-1:0] ev_set;
  assign ev_set[`PCRLC_EV_SUPPLY_LOW] = supply_low_s & ~supply_low_d_ff;
  assign ev_set[`PCRLC_EV_BANDGAP] = bandgap_s & ~bandgap_d_ff;
  assign ev_set[`PCRLC_EV_RST_DONE] = stretch_done;
  // Ordering faults by the outside party are reported, not blocked
  assign ev_set[`PCRLC_EV_SEQ_ERR] = (req_rise & ~io_s) |
                                     (io_fall & req_s);
  assign ev_set[`PCRLC_EV_RECAL] = recal_ev;
  assign ev_set[`PCRLC_EV_SETTLED] = settle_ev;

  wire [31:0] state_word;
  assign state_word = {10'h000, trim_ff[7:0], cap_q_ff, cpu_sel_ff,
                       pstate_ff, settled_ff, chip_rst_ff, bandgap_s,
                       supply_low_s};

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  reg [31:0] nxt_rdata;
  always @* begin
    case (wb_adr_i)
      `PCRLC_ADR_CTRL: nxt_rdata = {22'h000000, ctrl_ff};
      `PCRLC_ADR_STATUS: nxt_rdata = {26'h0000000, status_ff};
      `PCRLC_ADR_MASK: nxt_rdata = {26'h0000000, mask_ff};
      `PCRLC_ADR_STATE: nxt_rdata = state_word;
      `PCRLC_ADR_RECAL: nxt_rdata = {16'h0000, recal_per_ff};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  wire [31:0] ctrl_w;
  wire [31:0] mask_w;
  wire [31:0] recal_w;
  assign ctrl_w = wmerge({22'h000000, ctrl_ff}, wb_dat_i, wb_sel_i);
  assign mask_w = wmerge({26'h0000000, mask_ff}, wb_dat_i, wb_sel_i);
  assign recal_w = wmerge({16'h0000, recal_per_ff}, wb_dat_i, wb_sel_i);

  always @(posedge clk) begin
    if (srst) begin
      ctrl_ff <= `PCRLC_CTRL_RST;
      mask_ff <= `PCRLC_MASK_RST;
      recal_per_ff <= `PCRLC_RECAL_RST;
      status_ff <= {`PCRLC_EV_WIDTH{1'b0}};
      rdata_ff <= 32'h00000000;
      ack_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
      if (bus_rd) begin
        rdata_ff <= nxt_rdata;
      end
      if (bus_wr && wb_adr_i == `PCRLC_ADR_CTRL) begin
        ctrl_ff <= ctrl_w[`PCRLC_CTRL_WIDTH-1:0];
      end
      if (bus_wr && wb_adr_i == `PCRLC_ADR_MASK) begin
        mask_ff <= mask_w[`PCRLC_EV_WIDTH-1:0];
      end
      if (bus_wr && wb_adr_i == `PCRLC_ADR_RECAL) begin
        recal_per_ff <= (recal_w[15:0] == 16'h0000) ? 16'h0001 :
                        recal_w[15:0];
      end
      // A new event in the clearing cycle survives the read
      if (bus_rd && wb_adr_i == `PCRLC_ADR_STATUS) begin
        status_ff <= ev_set;
      end else begin
        status_ff <= status_ff | ev_set;
      end
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_dat_o = rdata_ff;
  assign wb_ack_o = ack_ff;
  assign irq = irq_ff;
  assign chip_rst = chip_rst_ff;
  assign slow_clock_settled = settled_ff;
  assign lp_clk_en = lp_en_ff;
  assign cpu_clk_sel = cpu_sel_ff;
  assign pwr_state = pstate_ff;
  assign load_cap_code = ctrl_ff[`PCRLC_CTRL_CAP_LSB +: 3];
  assign load_cap_boost = ctrl_ff[`PCRLC_CTRL_BOOST];
  assign xo_trim = trim_ff;

endmodule // pcrlc_top

// file: pcrlc_props.sv
`timescale 1ns/10ps
`include "pcrlc_defs.vh"

module pcrlc_props #(
  parameter RC2M_DIV = 20,
  parameter SETTLE_CYC = 400,
  parameter TRIM_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Pins
  input wire supply_low_det,
  input wire bandgap_drop_detect,
  input wire pwr_up_req,
  input wire radio_busy,
  input wire [TRIM_W-1:0] fuse_xo_trim,
  // Outputs watched
  input wire chip_rst,
  input wire slow_clock_settled,
  input wire lp_clk_en,
  input wire [1:0] cpu_clk_sel,
  input wire [1:0] pwr_state,
  input wire [TRIM_W-1:0] xo_trim
);
  localparam int STRETCH = 256 * 64 * RC2M_DIV;
  localparam int MAXST = STRETCH + 4 * RC2M_DIV + 8;
  // Run lengths, saturated so they never wrap
  int quiet_ff;
  int req_ff;
  always @(posedge clk) begin
    if (srst || supply_low_det || bandgap_drop_detect) quiet_ff <= 0;
    else if (quiet_ff < 2 * STRETCH) quiet_ff <= quiet_ff + 1;
    if (srst || !pwr_up_req) req_ff <= 0;
    else if (req_ff < 2 * SETTLE_CYC) req_ff <= req_ff + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_low_rst; $rose(supply_low_det) |-> ##[1:5] chip_rst; endproperty
  a_low_rst: assert property (p_low_rst) else $error("no reset");
  property p_bg_rst; $rose(bandgap_drop_detect) |-> ##[1:5] chip_rst;
  endproperty
  a_bg_rst: assert property (p_bg_rst) else $error("no reset");
  property p_min_st; $fell(chip_rst) |-> quiet_ff >= STRETCH - RC2M_DIV;
  endproperty
  a_min_st: assert property (p_min_st) else $error("short reset");
  property p_max_st; chip_rst |-> quiet_ff <= MAXST; endproperty
  a_max_st: assert property (p_max_st) else $error("long reset");
  property p_settle; $rose(slow_clock_settled) |-> req_ff >= SETTLE_CYC;
  endproperty
  a_settle: assert property (p_settle) else $error("early settle");
  property p_down; !pwr_up_req [*4] |-> pwr_state == `PCRLC_PS_DOWN;
  endproperty
  a_down: assert property (p_down) else $error("not down");
  // Settle may drop in the edge that launches the last tick
  property p_lp_en; lp_clk_en |-> $past(slow_clock_settled) ##1 !lp_clk_en;
  endproperty
  a_lp_en: assert property (p_lp_en) else $error("bad tick");
  property p_radio;
    (radio_busy && !chip_rst) [*2] |-> cpu_clk_sel == `PCRLC_CPU_XO26;
  endproperty
  a_radio: assert property (p_radio) else $error("not crystal");
  property p_trim; !chip_rst |-> xo_trim == fuse_xo_trim; endproperty
  a_trim: assert property (p_trim) else $error("trim lost");
  c_release: cover property ($fell(chip_rst));
  c_settle: cover property ($rose(slow_clock_settled));
  c_radio: cover property (radio_busy && cpu_clk_sel == `PCRLC_CPU_XO26);
  c_tick: cover property (lp_clk_en);
endmodule // pcrlc_props

bind pcrlc_top pcrlc_props #(
  .RC2M_DIV(RC2M_DIV), .SETTLE_CYC(SETTLE_CYC), .TRIM_W(TRIM_W)
) i_pcrlc_props (
  .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .supply_low_det(supply_low_det),
  .bandgap_drop_detect(bandgap_drop_detect), .pwr_up_req(pwr_up_req),
  .radio_busy(radio_busy), .fuse_xo_trim(fuse_xo_trim),
  .chip_rst(chip_rst), .slow_clock_settled(slow_clock_settled),
  .lp_clk_en(lp_clk_en), .cpu_clk_sel(cpu_clk_sel),
  .pwr_state(pwr_state), .xo_trim(xo_trim)
);

// file: pcrlc_board_model.sv
`timescale 1ns/10ps

module pcrlc_board_model (
  // Clock
  input wire clk,
  // Pins toward the block
  output logic io_supply,
  output logic pwr_up_req
);
  // Both pins driven from time zero, never floating
  initial begin
    io_supply = 1'b0;
    pwr_up_req = 1'b0;
  end
  // Request follows only with the supply up
  task automatic set_req(input logic v);
    @(posedge clk);
    pwr_up_req <= v & io_supply;
  endtask
  task automatic power_up();
    @(posedge clk);
    io_supply <= 1'b1;
    repeat (4) @(posedge clk);
    pwr_up_req <= 1'b1;
  endtask
  task automatic power_down();
    @(posedge clk);
    pwr_up_req <= 1'b0;
    repeat (4) @(posedge clk);
    io_supply <= 1'b0;
  endtask
  // Deliberate fault: supply lost under a raised request
  task automatic drop_supply();
    @(posedge clk);
    io_supply <= 1'b0;
  endtask
endmodule // pcrlc_board_model

// file: tb_power_reset_lowclk_ctrl.sv
`timescale 1ns/10ps
`include "pcrlc_defs.vh"

module tb_power_reset_lowclk_ctrl;
  // Short 2MHz divide keeps the stretch near 33k cycles
  localparam int DIV = 2;
  localparam int STRETCH = 256 * 64 * DIV;
  localparam logic [7:0] FUSE = 8'h5a;
  logic clk, srst, cyc, stb, we, radio_busy, low_det, bg_det;
  logic [7:0] adr;
  logic [31:0] wdat, q;
  logic [3:0] sel;
  logic [11:0] rows [8];
  wire [31:0] rdat;
  wire ack, irq, io_sup, req, chip_rst, settled, lp_en, boost;
  wire [1:0] cpu_sel, pstate;
  wire [2:0] cap_code;
  wire [7:0] trim;
  int failures, check_count, n, i;

  pcrlc_board_model i_pcrlc_board_model (
    .clk(clk), .io_supply(io_sup), .pwr_up_req(req));
  pcrlc_top #(.RC2M_DIV(DIV)) i_pcrlc_top (
    .clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq(irq), .supply_low_det(low_det),
    .bandgap_drop_detect(bg_det), .pwr_up_req(req), .io_supply(io_sup),
    .radio_busy(radio_busy), .fuse_xo_trim(FUSE), .chip_rst(chip_rst),
    .slow_clock_settled(settled), .lp_clk_en(lp_en), .cpu_clk_sel(cpu_sel),
    .pwr_state(pstate), .load_cap_code(cap_code), .load_cap_boost(boost),
    .xo_trim(trim));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic step(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Waits for ack with no limit; only the watchdog ends a wait for an ack that never comes
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic lp_gap(output int g);
    int k;
    k = 0;
    while (lp_en !== 1'b1 && k < 500) begin step(1); k++; end
    step(1);
    g = 1;
    while (lp_en !== 1'b1 && g < 500) begin step(1); g++; end
  endtask
  task close_out;
    $display("Counts: %0d checks, %0d failures", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    step(60000);
    failures++;
    close_out();
  end

  initial begin
    {srst, low_det} = 2'b11;
    {cyc, stb, we, radio_busy, bg_det} = 5'h00;
    {adr, wdat, sel} = {8'h00, 32'h0, 4'hf};
    {failures, check_count} = 0;
    // {ctrl, expected cpu clock select}
    rows = '{12'h000, 12'h105, 12'h20a, 12'h30c,
             12'h421, 12'hd00, 12'h60a, 12'hf21};
    step(12);
    chk(chip_rst, 1);
    chk({pstate, cap_code}, 0);
    srst <= 1'b0;
    wb(0, `PCRLC_ADR_RECAL, 0);
    chk(q, 32'h100);
    wb(1, 8'h14, 32'hffff_ffff);
    wb(0, 8'h14, 0);
    chk(q, 0);
    $display("test reset done");
    i_pcrlc_board_model.power_up();
    step(200);
    low_det <= 1'b0;
    step(1000);
    bg_det <= 1'b1;
    step(10);
    bg_det <= 1'b0;
    chk(pstate, `PCRLC_PS_DOWN);
    n = 0;
    while (chip_rst !== 1'b0 && n < STRETCH + 200) begin step(1); n++; end
    chk(n >= STRETCH - DIV && n <= STRETCH + 4 * DIV + 8, 1);
    step(4);
    chk(pstate, `PCRLC_PS_CPU);
    chk(trim, FUSE);
    $display("test stretch done");
    i_pcrlc_board_model.set_req(0);
    step(6);
    chk({pstate, settled}, 0);
    i_pcrlc_board_model.set_req(1);
    n = 0;
    while (settled !== 1'b1 && n < 1000) begin step(1); n++; end
    chk(n >= 400 && n <= 408, 1);
    $display("test settle done");
    for (i = 0; i < 8; i++) begin
      wb(1, `PCRLC_ADR_CTRL, rows[i][11:2]);
      step(2);
      chk(cpu_sel, rows[i][1:0]);
      chk({boost, cap_code}, rows[i][11:8]);
      wb(0, `PCRLC_ADR_STATE, 0);
      chk(q[13:8], 4 + 5 * rows[i][10:8] + 20 * rows[i][11]);
    end
    $display("test table done");
    for (i = 0; i < 2; i++) begin
      wb(1, `PCRLC_ADR_CTRL, i << 2);
      lp_gap(n);
      lp_gap(n);
      chk(n, i ? 64 * DIV : DIV);
    end
    $display("test tick done");
    wb(1, `PCRLC_ADR_RECAL, 1);
    radio_busy <= 1'b1;
    wb(0, `PCRLC_ADR_STATUS, 0);
    step(300);
    chk(cpu_sel, `PCRLC_CPU_XO26);
    wb(0, `PCRLC_ADR_STATUS, 0);
    chk(q[4], 1);
    chk(irq, 0);
    radio_busy <= 1'b0;
    wb(1, `PCRLC_ADR_CTRL, 32'h30);
    step(3);
    chk(pstate, `PCRLC_PS_RADIO);
    chk(cpu_sel, `PCRLC_CPU_XO26);
    $display("test radio done");
    wb(1, `PCRLC_ADR_MASK, 1 << `PCRLC_EV_SEQ_ERR);
    wb(0, `PCRLC_ADR_STATUS, 0);
    i_pcrlc_board_model.power_down();
    i_pcrlc_board_model.power_up();
    step(8);
    chk(irq, 0);
    i_pcrlc_board_model.drop_supply();
    step(8);
    chk(irq, 1);
    wb(0, `PCRLC_ADR_STATUS, 0);
    chk(q[3], 1);
    step(2);
    chk(irq, 0);
    $display("test irq done");
    low_det <= 1'b1;
    step(6);
    chk(chip_rst, 1);
    wb(0, `PCRLC_ADR_STATUS, 0);
    chk(q[0], 1);
    $display("test detector done");
    close_out();
  end
endmodule // tb_power_reset_lowclk_ctrl
